// ==== bench/energy_sense_chk_sva.sv ====
// Port checker for the energy-sense power control block
`timescale 1ns/10ps
module energy_sense_chk
  import energy_sense_pkg::*;
#(
  parameter longint IDLE_CYCLES = IDLE_TIMEOUT_CYCLES,
  parameter int COUNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic line_data_event,
  input wire logic line_error_event,
  input wire logic line_no_energy,
  input wire logic analog_power_up,
  input wire logic energy_pulse,
  input wire logic energy_state_irq
);
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] burst_cnt;
  logic hit;
  assign hit = mgmt_addr == ENERGY_SENSE_CONTROL_ADDR;
  // Saturates so a runaway burst cannot wrap back under the limit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) burst_cnt <= 4'h0;
    else if ($rose(analog_power_up)) burst_cnt <= 4'h0;
    else if (energy_pulse && burst_cnt != 4'hf) burst_cnt <= burst_cnt + 4'h1;
  end
  sequence s_man_wr;
    mgmt_write && hit && mgmt_wdata[ENABLE_BIT] && mgmt_wdata[MANUAL_BIT];
  endsequence
  sequence s_toggle;
    $changed(analog_power_up) && energy_state_irq;
  endsequence
  chk_manual_toggle: assert property (s_man_wr |-> ##2 s_toggle)
    else $error("no manual toggle");
  chk_manual_clears: assert property (mgmt_read && hit && !$past(mgmt_write)
    && !$past(mgmt_write, 2) |=> !mgmt_rdata[MANUAL_BIT]) else $error("manual bit stuck");
  chk_irq_cause: assert property (energy_state_irq |-> $changed(analog_power_up))
    else $error("irq without change");
  chk_irq_single: assert property (energy_state_irq |=> !energy_state_irq)
    else $error("irq too long");
  chk_pulse_gap: assert property (energy_pulse |=> !energy_pulse [*7])
    else $error("pulse gap short");
  chk_first_pulse: assert property ($rose(analog_power_up) |=> energy_pulse)
    else $error("no pulse at power-up");
  chk_burst_max: assert property (burst_cnt <= 4'(BURST_PULSES))
    else $error("burst too long");
  chk_state_shown: assert property (mgmt_read && hit ##1 mgmt_rdata[ENABLE_BIT]
    |-> mgmt_rdata[POWER_STATE_BIT] == $past(analog_power_up)) else $error("state bit wrong");
  chk_disabled_quiet: assert property (mgmt_read ##1 !mgmt_rdata[ENABLE_BIT]
    |-> mgmt_rdata[POWER_STATE_BIT:DATA_MET_BIT] == 3'h0) else $error("flags while disabled");
endmodule
bind energy_sense_ctrl energy_sense_chk #(.IDLE_CYCLES(IDLE_CYCLES), .COUNT_W(COUNT_W)) energy_sense_chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .line_data_event(line_data_event), .line_error_event(line_error_event), .line_no_energy(line_no_energy),
  .analog_power_up(analog_power_up), .energy_pulse(energy_pulse), .energy_state_irq(energy_state_irq));

// ==== bench/energy_sense_ctrl_tb_top.sv ====
// Testbench for the energy-sense power control block
`timescale 1ns/10ps
module energy_sense_ctrl_tb_top;
  import energy_sense_pkg::*;
  typedef struct {logic [15:0] w; logic [15:0] e;} row_t;
  row_t rows [4] = '{'{16'h0000, 16'h0000}, '{16'h68a5, 16'h68a5}, '{16'h06ff, 16'h00ff}, '{16'h1000, 16'h0000}};
  logic sys_clk;
  logic rst_b;
  logic mgmt_write;
  logic mgmt_read;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic line_data_event, line_error_event, line_no_energy;
  logic analog_power_up, energy_pulse, energy_state_irq;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int pulses = 0;
  int irqs = 0;
  // ------------------------------
  // Design, partner and clock
  // ------------------------------
  energy_sense_ctrl #(.IDLE_CYCLES(50)) energy_sense_ctrl_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .line_data_event(line_data_event), .line_error_event(line_error_event), .line_no_energy(line_no_energy),
    .analog_power_up(analog_power_up), .energy_pulse(energy_pulse), .energy_state_irq(energy_state_irq));
  line_partner line_partner_i (.sys_clk(sys_clk), .data_event(line_data_event),
    .error_event(line_error_event), .no_energy(line_no_energy));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (energy_pulse === 1'b1) pulses++;
    if (energy_state_irq === 1'b1) irqs++;
    if (cycles == 2000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic cmp_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_cnt(input string n, input int e, input int g);
    checked++;
    if (g != e) begin
      miscompares++;
      $display("unexpected %s: expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] w);
    @(posedge sys_clk);
    mgmt_write <= 1'b1;
    mgmt_addr <= ENERGY_SENSE_CONTROL_ADDR;
    mgmt_wdata <= w;
    @(posedge sys_clk);
    mgmt_write <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] e, input logic [4:0] a = ENERGY_SENSE_CONTROL_ADDR);
    @(posedge sys_clk);
    mgmt_read <= 1'b1;
    mgmt_addr <= a;
    @(posedge sys_clk);
    mgmt_read <= 1'b0;
    @(negedge sys_clk);
    cmp_reg("rdata", e, mgmt_rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    rst_b <= 1'b0;
    mgmt_write <= 1'b0;
    mgmt_read <= 1'b0;
    mgmt_addr <= 5'h00;
    mgmt_wdata <= 16'h0000;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(16'h6011);
    foreach (rows[i]) begin
      wr(rows[i].w);
      rd(rows[i].e);
    end
    wr(16'h8013);
    repeat (2) line_partner_i.ev(1'b0);
    rd(16'h8413);
    line_partner_i.ev(1'b0);
    line_partner_i.ev(1'b1);
    rd(16'h8713);
    cyc(60);
    rd(16'h0000, 5'h1c);
    rd(16'h8713);
    rd(16'h8413);
    irqs = 0;
    wr(16'h9013);
    cyc(4);
    cmp_reg("power", 16'h0000, {15'h0000, analog_power_up});
    rd(16'h8013);
    pulses = 0;
    wr(16'h9013);
    cyc(40);
    cmp_cnt("pulses", 4, pulses);
    cmp_cnt("irqs", 2, irqs);
    wr(16'h9813);
    cyc(4);
    pulses = 0;
    wr(16'h9813);
    cyc(20);
    cmp_cnt("pulses", 1, pulses);
    wr(16'he011);
    line_partner_i.quiet(1'b1);
    cyc(6);
    cmp_reg("power", 16'h0000, {15'h0000, analog_power_up});
    line_partner_i.quiet(1'b0);
    line_partner_i.ev(1'b0);
    cyc(2);
    cmp_reg("power", 16'h0001, {15'h0000, analog_power_up});
    wr(16'h0000);
    rd(16'h0000);
    wr(16'h9011);
    rd(16'h8011);
    // ------------------------------
    // Mid-run reset while powered down
    // ------------------------------
    @(posedge sys_clk);
    rst_b <= 1'b0;
    cyc(2);
    cmp_reg("rdata", 16'h0000, mgmt_rdata);
    cmp_reg("power", 16'h0001, {15'h0000, analog_power_up});
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(16'h6011);
    final_report();
  end
endmodule

// ==== bench/line_partner.sv ====
// Cable partner model: energy, error and silence on the line
`timescale 1ns/10ps
module line_partner (
  input wire logic sys_clk,
  output logic data_event,
  output logic error_event,
  output logic no_energy
);
  initial begin
    data_event = 1'b0;
    error_event = 1'b0;
    no_energy = 1'b0;
  end
  // Held two cycles so the two-flop sync sees every edge
  task automatic ev(input bit err);
    @(posedge sys_clk);
    if (err) error_event <= 1'b1;
    else data_event <= 1'b1;
    repeat (2) @(posedge sys_clk);
    data_event <= 1'b0;
    error_event <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic quiet(input logic v);
    @(posedge sys_clk);
    no_energy <= v;
  endtask
endmodule

// ==== include/energy_sense_pkg.sv ====
// Package with register layout, reset values and timing counts for the energy-sense power control
//
// Contract
// - Power management acts only while enable set
// - Auto wake when data count reaches threshold
// - Auto sleep when line goes silent
// - Manual bit toggles state, then self-clears
// - Burst of pulses on each driver power-up while enable set
// - Burst disable sends a single pulse
// - Bit 10 shows current power state while enable set, reads zero while enable clear
// - Error threshold flag, clear on read
// - Data threshold flag, clear on read
// - Error threshold field, reset one
// - Data threshold field, reset one
// - Counters clear after two idle seconds
// - Power state change while enable set raises irq source
package energy_sense_pkg;

  localparam logic [4:0] ENERGY_SENSE_CONTROL_ADDR = 5'h1d;

  localparam int ENABLE_BIT = 15;
  localparam int AUTO_WAKE_BIT = 14;
  localparam int AUTO_SLEEP_BIT = 13;
  localparam int MANUAL_BIT = 12;
  localparam int BURST_DIS_BIT = 11;
  localparam int POWER_STATE_BIT = 10;
  localparam int ERR_MET_BIT = 9;
  localparam int DATA_MET_BIT = 8;
  localparam int ERR_THR_LSB = 4;
  localparam int DATA_THR_LSB = 0;

  localparam logic RESET_ENABLE = 1'b0;
  localparam logic RESET_AUTO_WAKE = 1'b1;
  localparam logic RESET_AUTO_SLEEP = 1'b1;
  localparam logic RESET_BURST_DIS = 1'b0;
  localparam logic [3:0] RESET_ERR_THR = 4'h1;
  localparam logic [3:0] RESET_DATA_THR = 4'h1;

  localparam longint CLK_HZ = 10000000;
  localparam longint IDLE_TIMEOUT_MS = 2000;
  localparam longint IDLE_TIMEOUT_CYCLES = (CLK_HZ / 1000) * IDLE_TIMEOUT_MS;
  localparam int BURST_PULSES = 4;
  localparam int PULSE_GAP_CYCLES = 8;

  typedef struct packed {
    logic data_event;
    logic error_event;
    logic no_energy;
  } line_events_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage

// ==== rtl/energy_sense_ctrl.sv ====
// Energy-detect power control: control register, event counting, power state and pulse bursts
`timescale 1ns/10ps
module energy_sense_ctrl
  import energy_sense_pkg::*;
#(
  parameter longint IDLE_CYCLES = IDLE_TIMEOUT_CYCLES,
  parameter int COUNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic line_data_event,
  input wire logic line_error_event,
  input wire logic line_no_energy,
  output logic analog_power_up,
  output logic energy_pulse,
  output logic energy_state_irq
);

  initial begin
    if (IDLE_CYCLES < 2 || IDLE_CYCLES > 64'h0000_0000_ffff_ffff || COUNT_W < 4 || COUNT_W > 16) begin
      $error("energy_sense_ctrl: unsupported parameters");
    end
  end

  // --------------------------------------------------
  // Line input synchronisers
  // --------------------------------------------------
  line_events_t line_meta_reg;
  line_events_t line_sync_reg;
  line_events_t line_prev_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_meta_reg <= '0;
      line_sync_reg <= '0;
      line_prev_reg <= '0;
    end else begin
      line_meta_reg <= '{line_data_event, line_error_event, line_no_energy};
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
    end
  end

  // Events are counted on rising edges so a long level counts once
  logic data_evt;
  logic err_evt;
  logic silent;
  assign data_evt = line_sync_reg.data_event && !line_prev_reg.data_event;
  assign err_evt = line_sync_reg.error_event && !line_prev_reg.error_event;
  assign silent = line_sync_reg.no_energy;

  // --------------------------------------------------
  // Control register
  // --------------------------------------------------
  mgmt_req_t req;
  logic sel;
  logic wr;
  logic rd;
  assign req = '{mgmt_write, mgmt_read, mgmt_addr, mgmt_wdata};
  assign sel = (req.addr == ENERGY_SENSE_CONTROL_ADDR);
  assign wr = req.write && sel;
  assign rd = req.read && sel;

  logic enable_reg;
  logic auto_wake_reg;
  logic auto_sleep_reg;
  logic burst_dis_reg;
  logic [3:0] err_thr_reg;
  logic [3:0] data_thr_reg;
  logic manual_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= RESET_ENABLE;
      auto_wake_reg <= RESET_AUTO_WAKE;
      auto_sleep_reg <= RESET_AUTO_SLEEP;
      burst_dis_reg <= RESET_BURST_DIS;
      err_thr_reg <= RESET_ERR_THR;
      data_thr_reg <= RESET_DATA_THR;
    end else if (wr) begin
      enable_reg <= req.wdata[ENABLE_BIT];
      auto_wake_reg <= req.wdata[AUTO_WAKE_BIT];
      auto_sleep_reg <= req.wdata[AUTO_SLEEP_BIT];
      burst_dis_reg <= req.wdata[BURST_DIS_BIT];
      err_thr_reg <= req.wdata[ERR_THR_LSB +: 4];
      data_thr_reg <= req.wdata[DATA_THR_LSB +: 4];
    end
  end

  // Self-clearing: holds one cycle, then acted on
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      manual_reg <= 1'b0;
    end else begin
      manual_reg <= wr && req.wdata[MANUAL_BIT];
    end
  end

  // --------------------------------------------------
  // Event counters and idle timer
  // --------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_MAX = '1;
  logic [COUNT_W-1:0] data_cnt_reg;
  logic [COUNT_W-1:0] err_cnt_reg;
  logic [31:0] idle_reg;
  logic idle_expired;
  assign idle_expired = (idle_reg == 32'(IDLE_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_reg <= 32'h0;
    end else if (!enable_reg || data_evt || idle_expired) begin
      idle_reg <= 32'h0;
    end else begin
      idle_reg <= idle_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_cnt_reg <= '0;
      err_cnt_reg <= '0;
    end else if (!enable_reg || idle_expired) begin
      data_cnt_reg <= '0;
      err_cnt_reg <= '0;
    end else begin
      if (data_evt && data_cnt_reg != COUNT_MAX) begin
        data_cnt_reg <= data_cnt_reg + 1'b1;
      end
      if (err_evt && err_cnt_reg != COUNT_MAX) begin
        err_cnt_reg <= err_cnt_reg + 1'b1;
      end
    end
  end

  logic data_met;
  logic err_met;
  assign data_met = enable_reg && (data_cnt_reg >= COUNT_W'(data_thr_reg));
  assign err_met = enable_reg && (err_cnt_reg >= COUNT_W'(err_thr_reg));

  // --------------------------------------------------
  // Sticky threshold flags, set beats read clear
  // --------------------------------------------------
  logic data_met_reg;
  logic err_met_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_met_reg <= 1'b0;
      err_met_reg <= 1'b0;
    end else begin
      // Dropped while the mode is off, so stale flags never show
      data_met_reg <= enable_reg && (data_met || (data_met_reg && !rd));
      err_met_reg <= enable_reg && (err_met || (err_met_reg && !rd));
    end
  end

  // --------------------------------------------------
  // Power state
  // --------------------------------------------------
  // Error events are informational only and never move the state
  logic power_reg;
  logic power_next;

  always_comb begin
    power_next = power_reg;
    if (!enable_reg) begin
      power_next = 1'b1; // Path stays up while mode is off
    end else if (manual_reg) begin
      power_next = !power_reg;
    end else if (!power_reg && auto_wake_reg && data_met) begin
      power_next = 1'b1;
    end else if (power_reg && auto_sleep_reg && silent) begin
      power_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_reg <= 1'b1;
    end else begin
      power_reg <= power_next;
    end
  end

  // One-cycle irq source on every change while the mode is on
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      energy_state_irq <= 1'b0;
    end else begin
      energy_state_irq <= enable_reg && (power_next != power_reg);
    end
  end

  // --------------------------------------------------
  // Pulse bursts on driver power-up
  // --------------------------------------------------
  logic burst_start;
  assign burst_start = enable_reg && power_next && !power_reg;

  pulse_burst_gen #(
    .PULSES(BURST_PULSES),
    .GAP(PULSE_GAP_CYCLES)
  ) u_burst (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(burst_start),
    .single(burst_dis_reg),
    .pulse(energy_pulse),
    .busy()
  );

  assign analog_power_up = power_reg;

  // --------------------------------------------------
  // Read data
  // --------------------------------------------------
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = 16'h0000;
    if (sel) begin
      rdata_next[ENABLE_BIT] = enable_reg;
      rdata_next[AUTO_WAKE_BIT] = auto_wake_reg;
      rdata_next[AUTO_SLEEP_BIT] = auto_sleep_reg;
      rdata_next[MANUAL_BIT] = manual_reg;
      rdata_next[BURST_DIS_BIT] = burst_dis_reg;
      rdata_next[POWER_STATE_BIT] = enable_reg && power_reg;
      rdata_next[ERR_MET_BIT] = err_met_reg;
      rdata_next[DATA_MET_BIT] = data_met_reg;
      rdata_next[ERR_THR_LSB +: 4] = err_thr_reg;
      rdata_next[DATA_THR_LSB +: 4] = data_thr_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata <= 16'h0000;
    end else if (req.read) begin
      mgmt_rdata <= rdata_next;
    end
  end

endmodule

// ==== rtl/pulse_burst_gen.sv ====
// Energy-detect pulse burst generator, started on each driver power-up while enable set
`timescale 1ns/10ps
module pulse_burst_gen
  import energy_sense_pkg::*;
#(
  parameter int PULSES = BURST_PULSES,
  parameter int GAP = PULSE_GAP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic single,
  output logic pulse,
  output logic busy
);

  initial begin
    if (PULSES < 1 || PULSES > 15 || GAP < 2 || GAP > 255) begin
      $error("pulse_burst_gen: unsupported parameters");
    end
  end

  logic [3:0] left_reg;
  logic [7:0] gap_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_reg <= 4'h0;
      gap_reg <= 8'h00;
      pulse <= 1'b0;
    end else if (start) begin
      left_reg <= single ? 4'h1 : 4'(PULSES);
      gap_reg <= 8'h00;
      pulse <= 1'b0;
    end else if (left_reg != 4'h0) begin
      if (gap_reg == 8'h00) begin
        pulse <= 1'b1;
        left_reg <= left_reg - 4'h1;
        gap_reg <= 8'(GAP - 1);
      end else begin
        pulse <= 1'b0;
        gap_reg <= gap_reg - 8'h01;
      end
    end else begin
      pulse <= 1'b0;
      if (gap_reg != 8'h00) begin
        gap_reg <= gap_reg - 8'h01;
      end
    end
  end

  assign busy = (left_reg != 4'h0) || pulse;

endmodule
